// ### include/wscm_defs.svh
// register numbers, command codes and field constants of the weighing status/command map
`ifndef WSCM_DEFS_SVH
`define WSCM_DEFS_SVH

// ----------------------------------------
// register numbers
// ----------------------------------------
`define WSCM_REG_AOUT 16'h0000
`define WSCM_REG_DIN 16'h0001
`define WSCM_REG_DOUT 16'h0002
`define WSCM_REG_LEVEL 16'h0003
`define WSCM_REG_SETPT 16'h0004
`define WSCM_REG_AIN 16'h0005
`define WSCM_REG_CMD 16'h0006
`define WSCM_REG_CMD_ERR 16'h0007
`define WSCM_REG_CLK_FIRST 16'h0008
`define WSCM_REG_CLK_LAST 16'h000D
`define WSCM_REG_TARE 16'h000E
`define WSCM_REG_VAL_LAST 16'h0016
`define WSCM_REG_FLT_FIRST 16'h0020
`define WSCM_REG_FLT_LAST 16'h0027

// ----------------------------------------
// widths and field layout
// ----------------------------------------
`define WSCM_WORD_W 16
`define WSCM_EXC_W 8
`define WSCM_NUM_IO 4
`define WSCM_MEM_AW 4
`define WSCM_MEM_DEPTH 16
`define WSCM_CLK_FIELD_W 8
`define WSCM_SCAN_LAST 4'h8
`define WSCM_SCAN_LVL_FIRST 4'h1
`define WSCM_SCAN_LVL_LAST 4'h4
`define WSCM_SCAN_SP_FIRST 4'h5
`define WSCM_FLT_BIAS 8'h7F

// ----------------------------------------
// command codes
// ----------------------------------------
`define WSCM_CMD_NONE 16'h0000
`define WSCM_CMD_START 16'h0001
`define WSCM_CMD_REMOTE_ON 16'h0002
`define WSCM_CMD_REMOTE_OFF 16'h0003
`define WSCM_CMD_TARE 16'h000A
`define WSCM_CMD_ZERO 16'h000B
`define WSCM_CMD_GROSS 16'h000C
`define WSCM_CMD_NET 16'h000D
`define WSCM_CMD_SHOW_WEIGHT 16'h000E
`define WSCM_CMD_SHOW_FLOW 16'h000F
`define WSCM_CMD_PRINT 16'h0010
`define WSCM_CMD_ACC_CLEAR 16'h0011
`define WSCM_CMD_ACC_PRINT 16'h0012
`define WSCM_CMD_SP_FIRST 16'h0064
`define WSCM_CMD_SP_LAST 16'h006B
`define WSCM_CMD_SP_ALL_ON 16'h0084
`define WSCM_CMD_SP_ALL_OFF 16'h0085

// ----------------------------------------
// exception and command error codes
// ----------------------------------------
`define WSCM_EXC_NONE 8'h00
`define WSCM_EXC_ADDR 8'h02
`define WSCM_EXC_VALUE 8'h03
`define WSCM_CERR_NONE 16'h0000
`define WSCM_CERR_UNKNOWN 16'h0001
`define WSCM_CERR_NOT_WAITING 16'h0002
`define WSCM_CERR_NOT_STARTED 16'h0003

`endif

// ### include/wscm_pkg.sv
// types shared by the weighing status/command map
package wscm_pkg;
    typedef enum logic [1:0] {
        WSCM_ST_WAIT = 2'b01,
        WSCM_ST_RUN = 2'b10
    } wscm_state_type;
    typedef logic [15:0] wscm_word_type;
endpackage

// ### include/wscm_mem_if.sv
// link between the register map and its value memory
`timescale 1ns/1ns
`include "wscm_defs.svh"
interface wscm_mem_if;
    logic wr_en;
    logic [`WSCM_MEM_AW-1:0] wr_addr;
    wscm_pkg::wscm_word_type wr_data;
    logic [`WSCM_MEM_AW-1:0] a_addr;
    wscm_pkg::wscm_word_type a_data;
    logic [`WSCM_MEM_AW-1:0] b_addr;
    wscm_pkg::wscm_word_type b_data;
    modport ctrl(output wr_en, wr_addr, wr_data, a_addr, b_addr, input a_data, b_data);
    modport mem(input wr_en, wr_addr, wr_data, a_addr, b_addr, output a_data, b_data);
endinterface

// ### verilog/wscm_value_mem.sv
// value memory: preset tare, levels and setpoints, one write and two registered reads
`timescale 1ns/1ns
`include "wscm_defs.svh"
module wscm_value_mem (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // access
    wscm_mem_if.mem mem_bus
);
    wscm_pkg::wscm_word_type store_reg [`WSCM_MEM_DEPTH];
    wscm_pkg::wscm_word_type a_data_reg;
    wscm_pkg::wscm_word_type b_data_reg;

    // cleared on reset so a read before any write is defined
    always_ff @(posedge clk) begin
        for (int i = 0; i < `WSCM_MEM_DEPTH; i++) begin
            if (srst) begin
                store_reg[i] <= '0;
            end else if (mem_bus.wr_en && mem_bus.wr_addr == `WSCM_MEM_AW'(i)) begin
                store_reg[i] <= mem_bus.wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        a_data_reg <= store_reg[mem_bus.a_addr];
        b_data_reg <= store_reg[mem_bus.b_addr];
    end

    assign mem_bus.a_data = a_data_reg;
    assign mem_bus.b_data = b_data_reg;
endmodule

// ### verilog/wscm_command_map.sv
// remote register map of the weighing instrument: status words, command register, values
//
// Functional notes
// digital input status word reports inputs 1-4 in bits 0-3
// digital output status word reports outputs 1-4 in bits 0-3
// level status bit n set while weight is above level n+1
// setpoint status: even bit active, next odd bit cycle done, bits 0-7
// command register always reads back as zero
// nonzero command code triggers one action, code zero does nothing
// disallowed command answers exception 03, cause in command error register
// code 1 starts instrument, valid only while waiting for start
// code 2 enters remote and locks keys, code 3 leaves it
// codes 10-13: auto tare, zero gross, gross mode, net mode
// code 14 shows weight, code 15 shows flow rate
// code 16 prints weight, 17 clears accumulated, 18 prints accumulated
// codes 100-107 switch single setpoints on (even) or off (odd), 132/133 all four
// analog input register gives volts with three decimals, about +-11 V
// analog output register gives the value sent, three decimals
// preset tare register is written and read back
// four level registers are read/write and act as supervision thresholds
// clock registers return the instrument time and date
// four setpoint registers are read/write and feed the setpoint function
// status word read as float returns sum of set bit weights
// unsupported register number answers exception 02
// all values travel as 16-bit holding registers
// undefined status bits read as zero
`timescale 1ns/1ns
`include "wscm_defs.svh"
module wscm_command_map (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register access
    input wire logic REQ,
    input wire logic WR,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    output logic ACK,
    output logic [15:0] RDATA,
    output logic [7:0] EXC_CODE,
    // instrument state in
    input wire logic [3:0] DIG_IN,
    input wire logic [3:0] DIG_OUT,
    input wire logic [15:0] WEIGHT,
    input wire logic [3:0] SP_DONE,
    input wire logic [15:0] ANALOG_IN_MV,
    input wire logic [15:0] ANALOG_OUT_MV,
    input wire logic [47:0] CLOCK_TIME,
    // modes out
    output logic RUNNING,
    output logic REMOTE_MODE,
    output logic KEYS_ENABLE,
    output logic NET_MODE,
    output logic FLOW_DISPLAY,
    output logic [3:0] SP_ACTIVE,
    // action pulses out
    output logic TARE_PULSE,
    output logic ZERO_PULSE,
    output logic PRINT_PULSE,
    output logic ACC_CLEAR_PULSE,
    output logic ACC_PRINT_PULSE,
    // stored values out
    output logic [15:0] PRESET_TARE,
    output logic [63:0] SETPOINT_VALUES
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic is_value_reg(input logic [15:0] a);
        is_value_reg = (a >= `WSCM_REG_TARE) && (a <= `WSCM_REG_VAL_LAST);
    endfunction

    function automatic logic is_clock_reg(input logic [15:0] a);
        is_clock_reg = (a >= `WSCM_REG_CLK_FIRST) && (a <= `WSCM_REG_CLK_LAST);
    endfunction

    function automatic logic is_float_reg(input logic [15:0] a);
        is_float_reg = (a >= `WSCM_REG_FLT_FIRST) && (a <= `WSCM_REG_FLT_LAST);
    endfunction

    // upper word of the single-precision form of a byte; lower word is always zero
    function automatic logic [15:0] float_hi(input logic [7:0] n);
        logic [2:0] msb;
        logic [7:0] norm;
        msb = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (n[i]) begin
                msb = 3'(i);
            end
        end
        norm = n << (3'h7 - msb);
        if (n == 8'h00) begin
            float_hi = 16'h0000;
        end else begin
            float_hi = {1'b0, `WSCM_FLT_BIAS + {5'h00, msb}, norm[6:0]};
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    wscm_pkg::wscm_state_type state_reg;
    wscm_pkg::wscm_state_type state_next;
    logic remote_reg;
    logic net_mode_reg;
    logic flow_disp_reg;
    logic [3:0] sp_active_reg;
    logic [3:0] sp_active_next;
    logic [3:0] level_flags_reg;
    wscm_pkg::wscm_word_type cmd_err_reg;
    logic tare_reg;
    logic zero_reg;
    logic print_reg;
    logic acc_clear_reg;
    logic acc_print_reg;
    logic s1_valid_reg;
    logic s1_mem_reg;
    wscm_pkg::wscm_word_type s1_direct_reg;
    logic [7:0] s1_exc_reg;
    logic ack_reg;
    wscm_pkg::wscm_word_type rdata_reg;
    logic [7:0] exc_reg;
    logic [3:0] scan_idx_reg;
    logic [3:0] scan_idx_d_reg;
    logic scan_valid_reg;
    wscm_pkg::wscm_word_type tare_val_reg;
    logic [63:0] sp_val_reg;

    wscm_mem_if mem_link();

    wscm_value_mem u_value_mem (
        .clk(CLK),
        .srst(SRST),
        .mem_bus(mem_link.mem)
    );

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    wire req_rd = REQ && !WR;
    wire req_wr = REQ && WR;
    wire addr_val = is_value_reg(ADDR);
    wire addr_clk = is_clock_reg(ADDR);
    wire addr_flt = is_float_reg(ADDR);
    wire addr_cmd = (ADDR == `WSCM_REG_CMD);
    wire addr_status = (ADDR >= `WSCM_REG_DIN) && (ADDR <= `WSCM_REG_SETPT);
    wire addr_plain = (ADDR == `WSCM_REG_AOUT) || (ADDR == `WSCM_REG_AIN)
        || (ADDR == `WSCM_REG_CMD_ERR);
    wire rd_legal = addr_val || addr_clk || addr_flt || addr_cmd || addr_status || addr_plain;
    wire wr_legal = addr_val || addr_cmd;
    wire addr_bad = (req_rd && !rd_legal) || (req_wr && !wr_legal);
    wire [15:0] val_off = ADDR - `WSCM_REG_TARE;
    wire [15:0] clk_off = ADDR - `WSCM_REG_CLK_FIRST;
    wire [15:0] flt_off = ADDR - `WSCM_REG_FLT_FIRST;

    // ----------------------------------------
    // status words
    // ----------------------------------------
    wscm_pkg::wscm_word_type status_words [`WSCM_NUM_IO];
    logic [7:0] sp_status;

    generate
        for (genvar g = 0; g < `WSCM_NUM_IO; g++) begin : g_sp
            assign sp_status[2*g] = sp_active_reg[g];
            assign sp_status[2*g+1] = SP_DONE[g];
        end
    endgenerate

    // upper bits tied low: four sources per word, eight for the setpoint word
    assign status_words[0] = {12'h000, DIG_IN};
    assign status_words[1] = {12'h000, DIG_OUT};
    assign status_words[2] = {12'h000, level_flags_reg};
    assign status_words[3] = {8'h00, sp_status};

    wire [1:0] status_idx = 2'(ADDR - `WSCM_REG_DIN);
    wire [1:0] flt_idx = flt_off[2:1];
    // bit weights summed and shown as float; only the low byte is ever populated
    wire [15:0] flt_word = flt_off[0] ? 16'h0000
        : float_hi(status_words[flt_idx][7:0]);
    wire [15:0] clk_word = {8'h00, CLOCK_TIME[clk_off[2:0]*`WSCM_CLK_FIELD_W +: 8]};

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire cmd_hit = req_wr && addr_cmd;
    wire [15:0] code = WDATA;
    wire [15:0] sp_off = code - `WSCM_CMD_SP_FIRST;
    wire code_sp = (code >= `WSCM_CMD_SP_FIRST) && (code <= `WSCM_CMD_SP_LAST);
    wire code_sp_all = (code == `WSCM_CMD_SP_ALL_ON) || (code == `WSCM_CMD_SP_ALL_OFF);
    wire code_basic = (code <= `WSCM_CMD_REMOTE_OFF);
    wire code_scale = (code >= `WSCM_CMD_TARE) && (code <= `WSCM_CMD_ACC_PRINT);
    wire code_known = code_basic || code_scale || code_sp || code_sp_all;
    wire in_wait = (state_reg == wscm_pkg::WSCM_ST_WAIT);
    wire start_bad = (code == `WSCM_CMD_START) && !in_wait;
    wire needs_run = (code_scale || code_sp || code_sp_all) && in_wait;
    wire [15:0] cmd_cause = !code_known ? `WSCM_CERR_UNKNOWN
        : start_bad ? `WSCM_CERR_NOT_WAITING
        : needs_run ? `WSCM_CERR_NOT_STARTED
        : `WSCM_CERR_NONE;
    wire cmd_refused = cmd_hit && (cmd_cause != `WSCM_CERR_NONE);
    wire cmd_ok = cmd_hit && !cmd_refused;
    // code zero passes as accepted but matches no action below
    wire do_code_none = (code == `WSCM_CMD_NONE);
    wire do_start = cmd_ok && (code == `WSCM_CMD_START);
    wire do_remote_on = cmd_ok && (code == `WSCM_CMD_REMOTE_ON);
    wire do_remote_off = cmd_ok && (code == `WSCM_CMD_REMOTE_OFF);
    wire do_gross = cmd_ok && (code == `WSCM_CMD_GROSS);
    wire do_net = cmd_ok && (code == `WSCM_CMD_NET);
    wire do_show_w = cmd_ok && (code == `WSCM_CMD_SHOW_WEIGHT);
    wire do_show_f = cmd_ok && (code == `WSCM_CMD_SHOW_FLOW);
    wire do_sp = cmd_ok && (code_sp || code_sp_all);
    wire sp_level = code_sp ? !sp_off[0] : (code == `WSCM_CMD_SP_ALL_ON);

    wire [7:0] exc_next = addr_bad ? `WSCM_EXC_ADDR
        : cmd_refused ? `WSCM_EXC_VALUE
        : `WSCM_EXC_NONE;

    // ----------------------------------------
    // direct read data
    // ----------------------------------------
    wire [15:0] direct_word = !req_rd || addr_bad ? 16'h0000
        : addr_cmd ? 16'h0000
        : addr_status ? status_words[status_idx]
        : addr_flt ? flt_word
        : addr_clk ? clk_word
        : (ADDR == `WSCM_REG_AIN) ? ANALOG_IN_MV
        : (ADDR == `WSCM_REG_AOUT) ? ANALOG_OUT_MV
        : cmd_err_reg;

    // ----------------------------------------
    // value memory access
    // ----------------------------------------
    assign mem_link.wr_en = req_wr && addr_val;
    assign mem_link.wr_addr = val_off[`WSCM_MEM_AW-1:0];
    assign mem_link.wr_data = WDATA;
    assign mem_link.a_addr = val_off[`WSCM_MEM_AW-1:0];
    assign mem_link.b_addr = scan_idx_reg;

    // ----------------------------------------
    // instrument state machine
    // ----------------------------------------
    always_comb begin
        case (state_reg)
            wscm_pkg::WSCM_ST_WAIT: begin
                state_next = do_start ? wscm_pkg::WSCM_ST_RUN : wscm_pkg::WSCM_ST_WAIT;
            end
            wscm_pkg::WSCM_ST_RUN: begin
                state_next = wscm_pkg::WSCM_ST_RUN;
            end
            default: begin
                state_next = wscm_pkg::WSCM_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= wscm_pkg::WSCM_ST_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // command effects
    // ----------------------------------------
    generate
        for (genvar g = 0; g < `WSCM_NUM_IO; g++) begin : g_spnext
            wire hit = code_sp_all || (code_sp && sp_off[2:1] == 2'(g));
            assign sp_active_next[g] = (do_sp && hit) ? sp_level : sp_active_reg[g];
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SRST) begin
            remote_reg <= 1'b0;
            net_mode_reg <= 1'b0;
            flow_disp_reg <= 1'b0;
            sp_active_reg <= 4'h0;
        end else begin
            remote_reg <= do_remote_on || (remote_reg && !do_remote_off);
            net_mode_reg <= do_net || (net_mode_reg && !do_gross);
            flow_disp_reg <= do_show_f || (flow_disp_reg && !do_show_w);
            sp_active_reg <= sp_active_next;
        end
    end

    // each accepted tare, zero, print or accumulator code fires one pulse; nothing fires for code zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tare_reg <= 1'b0;
            zero_reg <= 1'b0;
            print_reg <= 1'b0;
            acc_clear_reg <= 1'b0;
            acc_print_reg <= 1'b0;
        end else begin
            tare_reg <= cmd_ok && (code == `WSCM_CMD_TARE);
            zero_reg <= cmd_ok && (code == `WSCM_CMD_ZERO);
            print_reg <= cmd_ok && (code == `WSCM_CMD_PRINT);
            acc_clear_reg <= cmd_ok && (code == `WSCM_CMD_ACC_CLEAR);
            acc_print_reg <= cmd_ok && (code == `WSCM_CMD_ACC_PRINT);
        end
    end

    // cause kept until the next command write; a clean command clears it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cmd_err_reg <= `WSCM_CERR_NONE;
        end else if (cmd_hit && !do_code_none) begin
            cmd_err_reg <= cmd_cause;
        end else if (cmd_hit) begin
            cmd_err_reg <= `WSCM_CERR_NONE;
        end
    end

    // ----------------------------------------
    // answer pipeline
    // ----------------------------------------
    // two stages so memory reads and direct reads answer with the same latency
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s1_valid_reg <= 1'b0;
            s1_mem_reg <= 1'b0;
            s1_direct_reg <= 16'h0000;
            s1_exc_reg <= `WSCM_EXC_NONE;
        end else begin
            s1_valid_reg <= REQ;
            s1_mem_reg <= req_rd && addr_val;
            s1_direct_reg <= direct_word;
            s1_exc_reg <= exc_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            exc_reg <= `WSCM_EXC_NONE;
        end else begin
            ack_reg <= s1_valid_reg;
            rdata_reg <= s1_mem_reg ? mem_link.a_data : s1_direct_reg;
            exc_reg <= s1_exc_reg;
        end
    end

    // ----------------------------------------
    // value scan
    // ----------------------------------------
    // one entry per cycle: flags and exported values trail a write by up to ten cycles
    always_ff @(posedge CLK) begin
        if (SRST) begin
            scan_idx_reg <= 4'h0;
            scan_idx_d_reg <= 4'h0;
            scan_valid_reg <= 1'b0;
        end else begin
            scan_idx_reg <= (scan_idx_reg == `WSCM_SCAN_LAST) ? 4'h0 : scan_idx_reg + 4'h1;
            scan_idx_d_reg <= scan_idx_reg;
            scan_valid_reg <= 1'b1;
        end
    end

    wire scan_lvl = scan_valid_reg && (scan_idx_d_reg >= `WSCM_SCAN_LVL_FIRST)
        && (scan_idx_d_reg <= `WSCM_SCAN_LVL_LAST);
    wire scan_sp = scan_valid_reg && (scan_idx_d_reg >= `WSCM_SCAN_SP_FIRST);
    wire [3:0] lvl_pos = scan_idx_d_reg - `WSCM_SCAN_LVL_FIRST;
    wire [3:0] sp_pos = scan_idx_d_reg - `WSCM_SCAN_SP_FIRST;
    wire above = $signed(WEIGHT) > $signed(mem_link.b_data);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            level_flags_reg <= 4'h0;
            tare_val_reg <= 16'h0000;
            sp_val_reg <= 64'h0000_0000_0000_0000;
        end else begin
            if (scan_lvl) begin
                level_flags_reg[lvl_pos[1:0]] <= above;
            end
            if (scan_valid_reg && scan_idx_d_reg == 4'h0) begin
                tare_val_reg <= mem_link.b_data;
            end
            if (scan_sp) begin
                sp_val_reg[sp_pos[1:0]*`WSCM_WORD_W +: 16] <= mem_link.b_data;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign ACK = ack_reg;
    assign RDATA = rdata_reg;
    assign EXC_CODE = exc_reg;
    assign RUNNING = (state_reg == wscm_pkg::WSCM_ST_RUN);
    assign REMOTE_MODE = remote_reg;
    assign KEYS_ENABLE = !remote_reg;
    assign NET_MODE = net_mode_reg;
    assign FLOW_DISPLAY = flow_disp_reg;
    assign SP_ACTIVE = sp_active_reg;
    assign TARE_PULSE = tare_reg;
    assign ZERO_PULSE = zero_reg;
    assign PRINT_PULSE = print_reg;
    assign ACC_CLEAR_PULSE = acc_clear_reg;
    assign ACC_PRINT_PULSE = acc_print_reg;
    assign PRESET_TARE = tare_val_reg;
    assign SETPOINT_VALUES = sp_val_reg;
endmodule

// ### test/wscm_monitor.sv
// concurrent checks on the register port and mode outputs of the command map
`timescale 1ns/1ns
module wscm_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register access
    input wire logic REQ,
    input wire logic WR,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    input wire logic [7:0] EXC_CODE,
    // state and actions
    input wire logic [3:0] DIG_IN,
    input wire logic RUNNING,
    input wire logic REMOTE_MODE,
    input wire logic KEYS_ENABLE,
    input wire logic TARE_PULSE,
    input wire logic ZERO_PULSE,
    input wire logic PRINT_PULSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire logic cmd_wr = REQ && WR && ADDR == 16'h0006;
    a_cmd_reads_zero: assert property (
        REQ && !WR && ADDR == 16'h0006 |-> ##2 RDATA == 16'h0000 && EXC_CODE == 8'h00)
        else $error("command register read not zero");
    a_input_word: assert property (
        REQ && !WR && ADDR == 16'h0001 ##1 $stable(DIG_IN) ##1 $stable(DIG_IN)
        |-> RDATA == {12'h000, DIG_IN}) else $error("input status word wrong");
    a_bad_address: assert property (
        REQ && WR && ADDR == 16'h0005 |-> ##2 EXC_CODE == 8'h02)
        else $error("write to read-only place not refused");
    a_restart_refused: assert property (
        cmd_wr && WDATA == 16'h0001 && RUNNING |-> ##2 EXC_CODE == 8'h03)
        else $error("second start not refused");
    a_waiting_refused: assert property (
        cmd_wr && WDATA == 16'h000A && !RUNNING |=> !TARE_PULSE ##1 EXC_CODE == 8'h03)
        else $error("tare while waiting not refused");
    a_tare_one_pulse: assert property (
        cmd_wr && WDATA == 16'h000A && RUNNING |=> TARE_PULSE ##1 !TARE_PULSE)
        else $error("tare pulse wrong");
    a_zero_no_action: assert property (
        cmd_wr && WDATA == 16'h0000 |=> !(TARE_PULSE || ZERO_PULSE || PRINT_PULSE))
        else $error("code zero caused an action");
    a_remote_enter: assert property (
        cmd_wr && WDATA == 16'h0002 |=> REMOTE_MODE && !KEYS_ENABLE)
        else $error("remote entry failed");
    a_keys_follow: assert property (KEYS_ENABLE != REMOTE_MODE)
        else $error("keys not opposite to remote");
endmodule
bind wscm_command_map wscm_checker u_chk (.CLK(CLK), .SRST(SRST), .REQ(REQ), .WR(WR),
    .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .EXC_CODE(EXC_CODE), .DIG_IN(DIG_IN),
    .RUNNING(RUNNING), .REMOTE_MODE(REMOTE_MODE), .KEYS_ENABLE(KEYS_ENABLE),
    .TARE_PULSE(TARE_PULSE), .ZERO_PULSE(ZERO_PULSE), .PRINT_PULSE(PRINT_PULSE));

// ### test/wscm_master.sv
// remote master model: one request per call, answer taken at the acknowledging edge
`timescale 1ns/1ns
module wscm_master (
    // bus to the map
    input wire logic clk,
    output logic req,
    output logic wr,
    output logic [15:0] addr,
    output logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic [7:0] exc_code
);
    initial {req, wr, addr, wdata} = 34'h0_0000_0000;
    // idle bus shows inverted data so a stale value can never pass
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic [7:0] e);
        q = 16'h0000;
        e = 8'hFF;
        @(negedge clk);
        {req, wr, addr, wdata} = {1'b1, w, a, d};
        @(negedge clk);
        {req, wr, addr, wdata} = {1'b0, ~w, ~a, ~d};
        for (int i = 0; i < 2 && e === 8'hFF; i++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                q = rdata;
                e = exc_code;
            end
        end
    endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the weighing status/command map
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {logic w; logic [15:0] a, d, q; logic [7:0] e;} wscm_row_type;
    logic CLK, SRST, REQ, WR, ACK, RUNNING, REMOTE_MODE, KEYS_ENABLE, NET_MODE, FLOW_DISPLAY;
    logic TARE_PULSE, ZERO_PULSE, PRINT_PULSE, ACC_CLEAR_PULSE, ACC_PRINT_PULSE;
    logic [15:0] ADDR, WDATA, RDATA, PRESET_TARE, WEIGHT, ANALOG_IN_MV, ANALOG_OUT_MV, q;
    logic [7:0] EXC_CODE, e;
    logic [3:0] DIG_IN, DIG_OUT, SP_DONE, SP_ACTIVE, exp_sp;
    logic [47:0] CLOCK_TIME;
    logic [63:0] SETPOINT_VALUES;
    logic [4:0] seen;
    logic [15:0] codes [5] = '{16'h000A, 16'h000B, 16'h0010, 16'h0011, 16'h0012};
    int failures = 0;
    int tests_run = 0;
    wscm_row_type rows [20];
    always #5 CLK = ~CLK;
    always @(posedge CLK) seen <= seen | {TARE_PULSE, ZERO_PULSE, PRINT_PULSE,
        ACC_CLEAR_PULSE, ACC_PRINT_PULSE};
    wscm_command_map dut (.CLK(CLK), .SRST(SRST), .REQ(REQ), .WR(WR), .ADDR(ADDR),
        .WDATA(WDATA), .ACK(ACK), .RDATA(RDATA), .EXC_CODE(EXC_CODE), .DIG_IN(DIG_IN),
        .DIG_OUT(DIG_OUT), .WEIGHT(WEIGHT), .SP_DONE(SP_DONE), .ANALOG_IN_MV(ANALOG_IN_MV),
        .ANALOG_OUT_MV(ANALOG_OUT_MV), .CLOCK_TIME(CLOCK_TIME), .RUNNING(RUNNING),
        .REMOTE_MODE(REMOTE_MODE), .KEYS_ENABLE(KEYS_ENABLE), .NET_MODE(NET_MODE),
        .FLOW_DISPLAY(FLOW_DISPLAY), .SP_ACTIVE(SP_ACTIVE), .TARE_PULSE(TARE_PULSE),
        .ZERO_PULSE(ZERO_PULSE), .PRINT_PULSE(PRINT_PULSE), .ACC_CLEAR_PULSE(ACC_CLEAR_PULSE),
        .ACC_PRINT_PULSE(ACC_PRINT_PULSE), .PRESET_TARE(PRESET_TARE),
        .SETPOINT_VALUES(SETPOINT_VALUES));
    wscm_master m (.clk(CLK), .req(REQ), .wr(WR), .addr(ADDR), .wdata(WDATA), .ack(ACK),
        .rdata(RDATA), .exc_code(EXC_CODE));
    task automatic chk(input logic [63:0] seen_v, input logic [63:0] exp_v);
        tests_run++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic cmd(input logic [15:0] c, input logic [7:0] ee);
        m.xfer(1'b1, 16'h0006, c, q, e);
        chk(e, ee);
    endtask
    task automatic give_verdict;
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
    initial begin
        {CLK, SRST, seen, DIG_IN, DIG_OUT, SP_DONE} = {1'b0, 1'b1, 5'h00, 12'h5A3};
        {WEIGHT, ANALOG_IN_MV, ANALOG_OUT_MV} = {16'h0064, 16'hD4E2, 16'h0BB8};
        CLOCK_TIME = 48'h0605_0403_0201;
        // ----------------------------------------
        // ordinary accesses, instrument starts waiting
        // ----------------------------------------
        rows = '{'{1'b0, 16'h0001, '0, 16'h0005, '0},
            '{1'b0, 16'h0002, '0, 16'h000A, '0},
            '{1'b1, 16'h000F, 16'h0032, '0, '0}, '{1'b1, 16'h0010, 16'h00C8, '0, '0},
            '{1'b1, 16'h0013, 16'h0111, '0, '0}, '{1'b0, 16'h0013, '0, 16'h0111, '0},
            '{1'b1, 16'h000E, 16'h1234, '0, '0}, '{1'b0, 16'h000E, '0, 16'h1234, '0},
            '{1'b0, 16'h0004, '0, 16'h000A, '0},
            '{1'b0, 16'h0005, '0, 16'hD4E2, '0},
            '{1'b0, 16'h0000, '0, 16'h0BB8, '0},
            '{1'b0, 16'h000D, '0, 16'h0006, '0},
            '{1'b0, 16'h0006, '0, '0, '0},
            '{1'b1, 16'h0006, 16'h000A, '0, 8'h03}, '{1'b0, 16'h0007, '0, 16'h0003, '0},
            '{1'b1, 16'h0006, 16'h0001, '0, '0}, '{1'b1, 16'h0006, 16'h0001, '0, 8'h03},
            '{1'b1, 16'h0006, '0, '0, '0},
            '{1'b1, 16'h0005, '0, '0, 8'h02},
            '{1'b0, 16'h0020, '0, 16'h40A0, '0}};
        repeat (3) @(posedge CLK);
        @(negedge CLK) SRST = 1'b0;
        chk({RUNNING, KEYS_ENABLE, NET_MODE, SP_ACTIVE, PRESET_TARE}, 23'h20_0000);
        foreach (rows[i]) begin
            m.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
            chk({q, e}, {rows[i].q, rows[i].e});
        end
        chk({PRESET_TARE, SETPOINT_VALUES[15:0]}, 32'h1234_0111);
        for (int k = 0; k < 2; k++) begin
            @(negedge CLK) WEIGHT = 16'h00C8 + 16'(k);
            repeat (12) @(negedge CLK);
            m.xfer(1'b0, 16'h0003, 16'h0000, q, e);
            chk(q, k ? 16'h000F : 16'h000D);
        end
        exp_sp = 4'h0;
        for (logic [15:0] c = 16'h0064; c < 16'h006C; c++) begin
            cmd(c, 8'h00);
            exp_sp[c[2:1] + 2'h2] = ~c[0];
            chk(SP_ACTIVE, exp_sp);
        end
        cmd(16'h0084, 8'h00);
        m.xfer(1'b0, 16'h0004, 16'h0000, q, e);
        chk(q, 16'h005F);
        cmd(16'h0085, 8'h00);
        chk(SP_ACTIVE, 4'h0);
        cmd(16'h0002, 8'h00);
        cmd(16'h000D, 8'h00);
        cmd(16'h000F, 8'h00);
        chk({REMOTE_MODE, KEYS_ENABLE, NET_MODE, FLOW_DISPLAY}, 4'hB);
        cmd(16'h0003, 8'h00);
        cmd(16'h000C, 8'h00);
        cmd(16'h000E, 8'h00);
        chk({REMOTE_MODE, KEYS_ENABLE, NET_MODE, FLOW_DISPLAY}, 4'h4);
        for (int k = 0; k < 5; k++) begin
            @(negedge CLK) seen = 5'h00;
            cmd(codes[k], 8'h00);
            chk(seen, 5'h10 >> k);
        end
        give_verdict();
    end
endmodule
